// ==== hdl/acrc_pkg.sv ====
/*
 * Shared constants for the conversion control and readout block, and the
 * two-flop synchroniser used on every pin that enters the core clock.
 * Assumes a 200 MHz core clock; pin inputs are asynchronous to it.
 */
package acrc_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_MHZ        = 200;
   // Conversion time of the internal converter sequence, in ns.
   localparam int CONV_TIME_NS   = 4000;
   // Delay from the busy falling edge until results may be read, in ns.
   localparam int LATCH_TO_READ_DELAY_NS = 25;
   // Reset pulse width expected from the host, in ns.
   localparam int RESET_PULSE_NS = 50;
   localparam int CONV_CYC  = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC =
      (LATCH_TO_READ_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int TIMER_W   = 12;

   // ==========================================================
   // Result layout
   // ==========================================================
   localparam int RES_W     = 14;
   localparam int BUS_W     = 16;
   localparam int NUM_CH    = 8;
   localparam int GROUP_CH  = 4;
   localparam int BYTE_W    = 8;
   localparam int RES_MSB   = 13;

   // ==========================================================
   // Synchronised pin bundle, bit positions
   // ==========================================================
   localparam int PIN_CS_N  = 0;
   localparam int PIN_RD    = 1;
   localparam int PIN_ST1   = 2;
   localparam int PIN_ST2   = 3;
   localparam int PIN_RST   = 4;
   localparam int PIN_ISEL  = 5;
   localparam int PIN_BSEL  = 6;
   localparam int PIN_HBF   = 7;
   localparam int PIN_W     = 8;
   // Reset value of the bundle: strobes idle high, the rest low.
   localparam logic [7:0] PIN_RST_VAL = 8'h03;

   // ==========================================================
   // Core states
   // ==========================================================
   typedef enum logic [1:0] {
      ACRC_IDLE    = 2'b00,
      ACRC_CONVERT = 2'b01,
      ACRC_SETTLE  = 2'b10
   } acrc_state_t;

endpackage

`timescale 1ns/1ps

module acrc_sync #(
   parameter int          W       = 8,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clock_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } acrc_sync_t;

   acrc_sync_t s_q;
   acrc_sync_t s_d;

   // The first stage feeds only the second stage.
   always_comb begin
      s_d.meta   = async_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.stable;

endmodule

// ==== hdl/acrc_top.sv ====
/*
 * Conversion control and result readout for an eight-channel,
 * simultaneous-sampling 14-bit converter: start control, busy, result
 * bank, parallel, byte and serial readout, and the first-channel flag.
 * Assumes the converter core presents all eight results on core_result_i
 * by the end of the conversion time, and that the host keeps reads clear
 * of the busy falling edge so the result bank is still while read.
 */
`timescale 1ns/1ps

module acrc_top #(
   parameter int CONV_CYCLES   = acrc_pkg::CONV_CYC,
   parameter int SETTLE_CYCLES = acrc_pkg::SETTLE_CYC
) (
   input  wire logic                clock_i,
   input  wire logic                nrst_i,
   input  wire logic                serial_clock_i,
   input  wire logic                start_group_one_i,
   input  wire logic                start_group_two_i,
   input  wire logic                reset_i,
   input  wire logic                cs_n_i,
   input  wire logic                rd_n_i,
   input  wire logic                interface_select_i,
   input  wire logic                byte_mode_select_i,
   input  wire logic                high_byte_first_i,
   input  wire logic [111:0]        core_result_i,
   output logic                     hold_group_one_o,
   output logic                     hold_group_two_o,
   output logic                     busy_o,
   output logic                     results_ready_o,
   output logic [15:0]              data_o,
   output logic [15:0]              data_oe_o,
   output logic                     serial_out_one_o,
   output logic                     serial_out_two_o,
   output logic                     serial_oe_o,
   output logic                     first_channel_flag_o,
   output logic                     first_channel_flag_oe_o
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (CONV_CYCLES < 1 || CONV_CYCLES >= (1 << acrc_pkg::TIMER_W))
      $error("CONV_CYCLES out of timer range");
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << acrc_pkg::TIMER_W))
      $error("SETTLE_CYCLES out of timer range");
   if (acrc_pkg::NUM_CH * acrc_pkg::RES_W != 112)
      $error("Result bank does not match the core result port");
   if (acrc_pkg::RES_W + 2 != acrc_pkg::BUS_W)
      $error("Sign extension expects two spare bus lines");
   if (acrc_pkg::PIN_W != 8)
      $error("Pin bundle width does not match the pin list");

   localparam logic [11:0] CONV_LAST   = 12'(CONV_CYCLES - 1);
   localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYCLES - 1);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [acrc_pkg::PIN_W-1:0] pin_raw;
   logic [acrc_pkg::PIN_W-1:0] pin_s;

   assign pin_raw[acrc_pkg::PIN_CS_N] = cs_n_i;
   assign pin_raw[acrc_pkg::PIN_RD]   = rd_n_i;
   assign pin_raw[acrc_pkg::PIN_ST1]  = start_group_one_i;
   assign pin_raw[acrc_pkg::PIN_ST2]  = start_group_two_i;
   assign pin_raw[acrc_pkg::PIN_RST]  = reset_i;
   assign pin_raw[acrc_pkg::PIN_ISEL] = interface_select_i;
   assign pin_raw[acrc_pkg::PIN_BSEL] = byte_mode_select_i;
   assign pin_raw[acrc_pkg::PIN_HBF]  = high_byte_first_i;

   acrc_sync #(
      .W       (acrc_pkg::PIN_W),
      .RST_VAL (acrc_pkg::PIN_RST_VAL)
   ) u_pin_sync (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .async_i (pin_raw),
      .sync_o  (pin_s)
   );

   // ==========================================================
   // Core state
   // ==========================================================
   typedef struct packed {
      acrc_pkg::acrc_state_t state;
      logic                  hold1;
      logic                  hold2;
      logic [11:0]           timer;
      logic [7:0][13:0]      bank;
      logic                  ready;
      logic [2:0]            idx;
      logic                  phase;
      logic                  flag;
      logic [15:0]           data;
      logic                  rd_prev;
      logic                  st1_prev;
      logic                  st2_prev;
      logic                  rst_prev;
   } acrc_core_t;

   acrc_core_t c_q;
   acrc_core_t c_d;

   logic       st1_rise;
   logic       st2_rise;
   logic       rst_rise;
   logic       rd_fall;
   logic       rd_rise;
   logic       mode_par;
   logic       mode_byte;
   logic       mode_ser;
   logic [15:0] word_ext;

   assign st1_rise  = pin_s[acrc_pkg::PIN_ST1] & ~c_q.st1_prev;
   assign st2_rise  = pin_s[acrc_pkg::PIN_ST2] & ~c_q.st2_prev;
   assign rst_rise  = pin_s[acrc_pkg::PIN_RST] & ~c_q.rst_prev;
   assign rd_fall   = ~pin_s[acrc_pkg::PIN_RD] & c_q.rd_prev
                      & ~pin_s[acrc_pkg::PIN_CS_N];
   assign rd_rise   = pin_s[acrc_pkg::PIN_RD] & ~c_q.rd_prev
                      & ~pin_s[acrc_pkg::PIN_CS_N];
   // Interface selection from the straps.
   assign mode_par  = ~pin_s[acrc_pkg::PIN_ISEL];
   assign mode_byte = pin_s[acrc_pkg::PIN_ISEL]
                      & pin_s[acrc_pkg::PIN_BSEL];
   assign mode_ser  = pin_s[acrc_pkg::PIN_ISEL]
                      & ~pin_s[acrc_pkg::PIN_BSEL];

   always_comb begin
      c_d          = c_q;
      c_d.rd_prev  = pin_s[acrc_pkg::PIN_RD];
      c_d.st1_prev = pin_s[acrc_pkg::PIN_ST1];
      c_d.st2_prev = pin_s[acrc_pkg::PIN_ST2];
      c_d.rst_prev = pin_s[acrc_pkg::PIN_RST];
      word_ext     = 16'h0000;

      case (c_q.state)
         acrc_pkg::ACRC_IDLE: begin
            // Starts are only looked at in idle, not in a conversion or the settle delay.
            if (st1_rise) begin
               c_d.hold1 = 1'b1;
            end
            if (st2_rise) begin
               c_d.hold2 = 1'b1;
            end
            if (c_d.hold1 && c_d.hold2) begin
               c_d.state = acrc_pkg::ACRC_CONVERT;
               c_d.timer = 12'h000;
               c_d.ready = 1'b0;
            end
         end
         acrc_pkg::ACRC_CONVERT: begin
            // Start edges have no effect here.
            if (c_q.timer == CONV_LAST) begin
               c_d.state = acrc_pkg::ACRC_SETTLE;
               c_d.timer = 12'h000;
               c_d.hold1 = 1'b0;
               c_d.hold2 = 1'b0;
               c_d.bank  = core_result_i;
               c_d.idx   = 3'h0;
               c_d.phase = 1'b0;
            end else begin
               c_d.timer = c_q.timer + 12'h001;
            end
         end
         acrc_pkg::ACRC_SETTLE: begin
            if (c_q.timer == SETTLE_LAST) begin
               c_d.state = acrc_pkg::ACRC_IDLE;
               c_d.ready = 1'b1;
            end else begin
               c_d.timer = c_q.timer + 12'h001;
            end
         end
         default: begin
            c_d.state = acrc_pkg::ACRC_IDLE;
         end
      endcase

      // Parallel and byte reads: flag on the fall, advance on the rise.
      if (!mode_ser) begin
         if (rd_fall) begin
            c_d.flag = (c_q.idx == 3'h0) && !c_q.phase;
         end
         if (rd_rise) begin
            if (mode_byte && !c_q.phase) begin
               c_d.phase = 1'b1;
            end else begin
               c_d.phase = 1'b0;
               c_d.idx   = c_q.idx + 3'h1;
            end
         end
      end

      // A reset pin edge wins over everything above. It is a soft reset:
      // the straps and the edge detectors keep their state, so a start
      // held high across it does not count as a fresh edge afterwards.
      if (rst_rise) begin
         c_d.state = acrc_pkg::ACRC_IDLE;
         c_d.hold1 = 1'b0;
         c_d.hold2 = 1'b0;
         c_d.timer = 12'h000;
         c_d.bank  = '0;
         c_d.ready = 1'b0;
         c_d.idx   = 3'h0;
         c_d.phase = 1'b0;
         c_d.flag  = 1'b0;
      end

      // Output word: sign-extended result, or the byte due next.
      word_ext = {{2{c_d.bank[c_d.idx][acrc_pkg::RES_MSB]}},
                  c_d.bank[c_d.idx]};
      if (mode_byte) begin
         if (pin_s[acrc_pkg::PIN_HBF] ^ c_d.phase) begin
            c_d.data = {8'h00, word_ext[15:8]};
         end else begin
            c_d.data = {8'h00, word_ext[7:0]};
         end
      end else begin
         c_d.data = word_ext;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         c_q <= '{state:    acrc_pkg::ACRC_IDLE,
                  rd_prev:  1'b1,
                  default:  '0};
      end else begin
         c_q <= c_d;
      end
   end

   // ==========================================================
   // Serial link, on the host's serial clock
   // ==========================================================
   // The counters are cleared while chip select is high, so a frame
   // always starts at the channel 1 MSB without needing a clock edge.
   // The result bank is read directly: it only changes at the busy fall,
   // which the host keeps clear of its reads, and on a reset pin edge.
   typedef struct packed {
      logic [3:0] bitc;
      logic [1:0] word;
   } acrc_link_t;

   acrc_link_t l_q;
   acrc_link_t l_d;
   logic       l_done_q;
   logic       link_nrst;
   logic [3:0] bit_sel;
   logic [1:0] ser_bit;

   // Chip select gates the link reset straight from the pin. A glitch on
   // it can only restart the frame at the channel 1 MSB, which is what
   // the host asks for on every chip select fall anyway.
   assign link_nrst = nrst_i & ~cs_n_i;

   always_comb begin
      l_d = l_q;
      if (l_q.bitc == 4'hd) begin
         l_d.bitc = 4'h0;
         l_d.word = l_q.word + 2'h1;
      end else begin
         l_d.bitc = l_q.bitc + 4'h1;
      end
   end

   always_ff @(posedge serial_clock_i or negedge link_nrst) begin
      if (!link_nrst) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // The 14th falling edge comes after 13 rising edges in the frame.
   always_ff @(negedge serial_clock_i or negedge link_nrst) begin
      if (!link_nrst) begin
         l_done_q <= 1'b0;
      end else if (l_q.word == 2'h0 && l_q.bitc == 4'hd) begin
         l_done_q <= 1'b1;
      end
   end

   assign bit_sel = 4'hd - l_q.bitc;
   // Output one walks channels 1 to 4 and output two channels 5 to 8.
   for (genvar g = 0; g < 2; g++) begin : g_ser
      assign ser_bit[g] = c_q.bank[{1'(g), l_q.word}][bit_sel];
   end
   assign serial_out_one_o = ser_bit[0];
   assign serial_out_two_o = ser_bit[1];

   // ==========================================================
   // Pin drivers
   // ==========================================================
   logic bus_on;

   // Enables follow the pins directly so the bus floats at once.
   assign bus_on      = ~cs_n_i & ~rd_n_i;
   assign serial_oe_o = mode_ser & ~cs_n_i;
   assign data_oe_o   = (mode_par & bus_on) ? 16'hffff :
                        (mode_byte & bus_on) ? 16'h00ff :
                        16'h0000;
   // The word is registered from the next index, so it steps on the same edge as the index;
   // the strobe phases the host gives are far longer than that.
   assign data_o      = c_q.data;

   assign first_channel_flag_oe_o = ~cs_n_i;
   assign first_channel_flag_o    = mode_ser ? ~l_done_q
                                             : c_q.flag;

   assign busy_o           = (c_q.state == acrc_pkg::ACRC_CONVERT);
   assign results_ready_o  = c_q.ready;
   assign hold_group_one_o = c_q.hold1;
   assign hold_group_two_o = c_q.hold2;

endmodule

// ==== test/acrc_properties.sv ====
/*
 * Concurrent checks on the pins of acrc_top, bound into every instance.
 * Assumes the core clock samples the pins and that the reset pin aborts
 * a running conversion a few core cycles after it rises.
 */
`timescale 1ns/1ps

module acrc_properties #(
   parameter int CONV_CYCLES = 800
) (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic        start_group_one_i,
   input  wire logic        reset_i,
   input  wire logic        cs_n_i,
   input  wire logic        rd_n_i,
   input  wire logic        interface_select_i,
   input  wire logic        byte_mode_select_i,
   input  wire logic        hold_group_one_o,
   input  wire logic        hold_group_two_o,
   input  wire logic        busy_o,
   input  wire logic        results_ready_o,
   input  wire logic [15:0] data_o,
   input  wire logic [15:0] data_oe_o,
   input  wire logic        serial_oe_o,
   input  wire logic        first_channel_flag_o,
   input  wire logic        first_channel_flag_oe_o
);
   // ==========================================================
   // Helper state
   // ==========================================================
   logic [11:0] busy_cnt_q;
   logic        rst_seen_q;
   logic        par_rd;
   logic        serial_mode;

   assign par_rd      = !interface_select_i && !cs_n_i && !rd_n_i;
   assign serial_mode = interface_select_i && !byte_mode_select_i;

   // An aborted busy run is legally short, so remember a reset pin edge.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_cnt_q <= 12'h000;
         rst_seen_q <= 1'b0;
      end else begin
         busy_cnt_q <= busy_o ? busy_cnt_q + 12'h001 : 12'h000;
         rst_seen_q <= reset_i | (rst_seen_q & busy_o);
      end
   end

   // ==========================================================
   // Properties
   // ==========================================================
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   oe_drive_a:
      assert property (par_rd |-> data_oe_o == 16'hffff)
      else $error("Parallel bus not driven in a read.");
   oe_float_a:
      assert property ((cs_n_i || rd_n_i) |-> data_oe_o == 16'h0000)
      else $error("Data bus driven outside a read.");
   sign_ext_a:
      assert property (par_rd |-> data_o[15:14] == {2{data_o[13]}})
      else $error("Upper lines do not copy the sign bit.");
   byte_lines_a:
      assert property ((interface_select_i && byte_mode_select_i &&
         !cs_n_i && !rd_n_i) |-> data_oe_o == 16'h00ff)
      else $error("Byte read not on the low eight lines.");
   flag_float_a:
      assert property (first_channel_flag_oe_o == !cs_n_i)
      else $error("Flag enable does not follow chip select.");
   serial_oe_a:
      assert property (serial_mode |-> serial_oe_o == !cs_n_i)
      else $error("Serial outputs enable wrong.");
   serial_flag_a:
      assert property (($fell(cs_n_i) && serial_mode) |->
         ##[0:2] first_channel_flag_o)
      else $error("Serial flag not raised at frame start.");
   busy_both_a:
      assert property ($rose(busy_o) |->
         hold_group_one_o && hold_group_two_o)
      else $error("Busy rose without both groups in hold.");
   busy_hold_a:
      assert property ((busy_o && busy_cnt_q < CONV_CYCLES - 1 &&
         !rst_seen_q && !reset_i) |=> busy_o)
      else $error("Busy fell before the conversion time.");
   busy_end_a:
      assert property ((busy_o && busy_cnt_q == CONV_CYCLES - 1) |=>
         !busy_o)
      else $error("Busy outlasted the conversion time.");
   ready_late_a:
      assert property ($fell(busy_o) |-> !results_ready_o)
      else $error("Results readable with no latch delay.");
   ready_soon_a:
      assert property (($fell(busy_o) && !rst_seen_q) |->
         ##[1:8] results_ready_o)
      else $error("Results not readable after the delay.");
   hold_start_a:
      assert property (($rose(start_group_one_i) && results_ready_o &&
         !reset_i) |-> ##[1:4] hold_group_one_o)
      else $error("Group one not put into hold.");

   cover property ($fell(busy_o));
   cover property ($fell(cs_n_i) && serial_mode);
   cover property (!cs_n_i && !rd_n_i && interface_select_i &&
      byte_mode_select_i);
endmodule

bind acrc_top acrc_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
   .clock_i(clock_i), .nrst_i(nrst_i),
   .start_group_one_i(start_group_one_i), .reset_i(reset_i),
   .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
   .interface_select_i(interface_select_i),
   .byte_mode_select_i(byte_mode_select_i),
   .hold_group_one_o(hold_group_one_o),
   .hold_group_two_o(hold_group_two_o), .busy_o(busy_o),
   .results_ready_o(results_ready_o), .data_o(data_o),
   .data_oe_o(data_oe_o), .serial_oe_o(serial_oe_o),
   .first_channel_flag_o(first_channel_flag_o),
   .first_channel_flag_oe_o(first_channel_flag_oe_o));

// ==== test/acrc_host.sv ====
/*
 * Host model: drives both starts, the reset pin, chip select and the
 * read strobe, which doubles as the serial clock.
 * Assumes the bench calls its tasks and wires its outputs to the pins.
 */
`timescale 1ns/1ps

module acrc_host (
   output logic start_one_o,
   output logic start_two_o,
   output logic reset_o,
   output logic cs_n_o,
   output logic sclk_o
);
   // ==========================================================
   // Pin drive
   // ==========================================================
   // The serial clock idles high and only toggles inside a frame.
   initial begin
      start_one_o = 1'b0;
      start_two_o = 1'b0;
      reset_o     = 1'b0;
      cs_n_o      = 1'b1;
      sclk_o      = 1'b1;
   end

   // Separate starts are legal here since oversampling is never used.
   task automatic starts(input logic a, input logic b);
      start_one_o = a;
      start_two_o = b;
   endtask

   task automatic pulse_reset();
      reset_o = 1'b1;
      #50;
      reset_o = 1'b0;
   endtask

   task automatic frame(input logic lvl);
      cs_n_o = lvl;
      #32;
   endtask

   // One half of a 64 ns serial clock period, or one strobe phase.
   task automatic half(input logic lvl);
      sclk_o = lvl;
      #32;
   endtask
endmodule

// ==== test/acrc_top_tb.sv ====
/*
 * Self-checking bench for acrc_top: starts and busy, parallel, byte and
 * serial readout, and the reset pin.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps

module acrc_top_tb;
   // ==========================================================
   // Signals and instances
   // ==========================================================
   logic         clock_i;
   logic         nrst_i;
   logic         isel;
   logic         bsel;
   logic         hbf;
   logic [111:0] res;
   logic         st1, st2, rst, cs_n, sclk, hold1, hold2, busy, ready;
   logic         so1, so2, soe, flag, flag_oe;
   logic [15:0]  data, data_oe;
   int           fail_count  = 0;
   int           check_count = 0;
   int           cyc         = 0;
   int           off         = 0;

   always #2.5 clock_i = ~clock_i;

   acrc_host host (.start_one_o(st1), .start_two_o(st2), .reset_o(rst),
      .cs_n_o(cs_n), .sclk_o(sclk));

   acrc_top #(.CONV_CYCLES(8), .SETTLE_CYCLES(1)) uut (
      .clock_i(clock_i), .nrst_i(nrst_i), .serial_clock_i(sclk),
      .start_group_one_i(st1), .start_group_two_i(st2), .reset_i(rst),
      .cs_n_i(cs_n), .rd_n_i(sclk), .interface_select_i(isel),
      .byte_mode_select_i(bsel), .high_byte_first_i(hbf),
      .core_result_i(res), .hold_group_one_o(hold1),
      .hold_group_two_o(hold2), .busy_o(busy), .results_ready_o(ready),
      .data_o(data), .data_oe_o(data_oe), .serial_out_one_o(so1),
      .serial_out_two_o(so2), .serial_oe_o(soe),
      .first_channel_flag_o(flag), .first_channel_flag_oe_o(flag_oe));

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [13:0] chv(input int k);
      return 14'(k * 14'h0a5b + 14'h0c37);
   endfunction

   function automatic logic [15:0] sx(input int k);
      logic [13:0] v;
      v = chv(k);
      return {{2{v[13]}}, v};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Reads only start once results are ready, never while busy.
   task automatic conv();
      int i;
      int k;
      // Fresh results per conversion, so a stale bank cannot pass.
      off = off + 8;
      for (k = 0; k < 8; k++) res[14 * k +: 14] = chv(off + k);
      tick(1);
      host.starts(1'b1, 1'b1);
      tick(4);
      host.starts(1'b0, 1'b0);
      for (i = 0; i < 60 && ready !== 1'b1; i++) tick(1);
      chk(16'(ready), 16'h1);
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_convert();
      int i;
      host.starts(1'b1, 1'b0);
      tick(6);
      chk(16'({hold1, hold2, busy}), 16'h4);
      host.starts(1'b0, 1'b1);
      tick(4);
      chk(16'({hold1, hold2, busy}), 16'h7);
      host.starts(1'b1, 1'b1);
      tick(3);
      host.starts(1'b0, 1'b0);
      for (i = 0; i < 60 && ready !== 1'b1; i++) tick(1);
      tick(10);
      chk(16'({hold1, busy, ready}), 16'h1);
   endtask

   task automatic t_parallel();
      int k;
      isel = 1'b0;
      conv();
      host.frame(1'b0);
      for (k = 0; k < 8; k++) begin
         host.half(1'b0);
         chk(data_oe, 16'hffff);
         chk(data, sx(off + k));
         chk(16'({flag_oe, flag}), 16'({1'b1, k == 0}));
         host.half(1'b1);
         chk(data_oe, 16'h0000);
      end
      host.frame(1'b1);
      chk(16'(flag_oe), 16'h0);
   endtask

   task automatic t_byte(input logic first_hi);
      int i;
      logic [15:0] w;
      logic [15:0] e;
      isel = 1'b1;
      bsel = 1'b1;
      hbf = first_hi;
      conv();
      host.frame(1'b0);
      for (i = 0; i < 16; i++) begin
         w = sx(off + i / 2);
         e = (first_hi ^ i[0]) ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
         host.half(1'b0);
         chk(data_oe, 16'h00ff);
         chk(data, e);
         chk(16'(flag), 16'(i == 0));
         host.half(1'b1);
      end
      host.frame(1'b1);
   endtask

   task automatic t_serial();
      int i;
      logic [13:0] a;
      logic [13:0] b;
      isel = 1'b1;
      bsel = 1'b0;
      conv();
      host.frame(1'b0);
      chk(16'(soe), 16'h1);
      for (i = 0; i < 56; i++) begin
         a = chv(off + i / 14);
         b = chv(off + 4 + i / 14);
         chk(16'({so1, so2}), 16'({a[13 - i % 14], b[13 - i % 14]}));
         chk(16'(flag), 16'(i < 14));
         host.half(1'b0);
         host.half(1'b1);
      end
      host.frame(1'b1);
   endtask

   task automatic t_reset();
      isel = 1'b0;
      conv();
      host.frame(1'b0);
      host.half(1'b0);
      host.pulse_reset();
      tick(4);
      chk(data, 16'h0000);
      host.half(1'b1);
      host.frame(1'b1);
      tick(1);
      host.starts(1'b1, 1'b1);
      tick(5);
      host.pulse_reset();
      host.starts(1'b0, 1'b0);
      tick(20);
      chk(16'({busy, ready}), 16'h0);
   endtask

   // ==========================================================
   // Main sequence and hang guard
   // ==========================================================
   initial begin
      clock_i = 1'b0;
      nrst_i  = 1'b0;
      isel    = 1'b0;
      bsel    = 1'b0;
      hbf     = 1'b0;
      res     = '0;
      repeat (3) @(posedge clock_i);
      #1 nrst_i = 1'b1;
      host.pulse_reset();
      tick(3);
      t_convert();
      t_parallel();
      t_byte(1'b1);
      t_byte(1'b0);
      t_serial();
      t_reset();
      end_sim();
   end

   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         end_sim();
      end
   end
endmodule
